// ---- core/crtc_core.sv ----
`timescale 1ns/1ns
module crtc_core
   import crtc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Serial link
   input wire logic spi_clk,
   input wire logic chip_select_n,
   input wire logic mosi,
   output logic miso_out,
   output logic miso_oe,
   // Converter results
   input wire logic dual_done,
   input wire logic dual_soon,
   input wire logic [15:0] loss_result,
   input wire logic [15:0] ind_result,
   input wire logic hires_done,
   input wire logic [23:0] hires_result
);
   import crtc_pkg::*;

   // Link-clock side: frame state is cleared whenever the frame ends
   logic frame_rst;
   logic [2:0] bit_cnt_q;
   logic [6:0] shin_q;
   logic cmd_done_q;
   logic rd_mode_q;
   logic [6:0] ptr_q;
   logic [7:0] sd_q;
   logic rd_phase_q;
   // Burst capture survives the frame end so the system side can commit it
   logic [7:0] wbuf_q [BURST_MAX];
   logic [6:0] wstart_q;
   logic [3:0] wcnt_q;
   logic wr_frame_q;
   logic frame_tgl_q;
   logic dual_rd_q;
   logic hires_rd_q;
   logic [7:0] rd_data;

   // System side
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic tg_s1_q, tg_s2_q, tg_done_q;
   logic [15:0] loss_upper_limit_q, loss_lower_limit_q;
   logic [15:0] inductance_upper_limit_q, inductance_lower_limit_q;
   logic [15:0] loss_upper_limit_d, loss_lower_limit_d;
   logic [15:0] inductance_upper_limit_d, inductance_lower_limit_d;
   logic [7:0] irq_route_reg_q, irq_route_reg_d;
   logic route_hit;
   logic loss_above_q, loss_win_q, ind_above_q, ind_win_q;
   logic latch_q, dual_irq_q, dual_pend_q;
   logic int_q, int_oe_q;
   logic [7:0] snap_status_q;
   logic [15:0] snap_loss_q, snap_ind_q;
   logic [23:0] snap_hires_q;

   assign frame_rst = reset | chip_select_n;

   wire [7:0] rx_byte = {shin_q, mosi};
   wire byte_end = (bit_cnt_q == 3'h7);
   wire data_byte_end = byte_end & cmd_done_q;

   always_ff @(posedge spi_clk or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         bit_cnt_q <= 3'h0;
         shin_q <= 7'h00;
         cmd_done_q <= 1'b0;
         rd_mode_q <= 1'b0;
         ptr_q <= 7'h00;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shin_q <= rx_byte[6:0];
         if (byte_end && !cmd_done_q)
         begin
            cmd_done_q <= 1'b1;
            rd_mode_q <= rx_byte[7];
            ptr_q <= rx_byte[6:0];
         end
         else if (byte_end)
            ptr_q <= ptr_q + 7'h01;
      end
   end

   wire ptr_is_hires = (ptr_q == ADDR_HIRES_0) | (ptr_q == ADDR_HIRES_1) |
                       (ptr_q == ADDR_HIRES_2);
   wire ptr_is_dual = (ptr_q >= ADDR_LOSS_RES_L) & (ptr_q <= ADDR_IND_RES_H);

   always_ff @(posedge spi_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < BURST_MAX; i++)
            wbuf_q[i] <= 8'h00;
         wstart_q <= 7'h00;
         wcnt_q <= 4'h0;
         wr_frame_q <= 1'b0;
         frame_tgl_q <= 1'b0;
         dual_rd_q <= 1'b0;
         hires_rd_q <= 1'b0;
      end
      else if (byte_end && !cmd_done_q)
      begin
         wstart_q <= rx_byte[6:0];
         wcnt_q <= 4'h0;
         wr_frame_q <= ~rx_byte[7];
         frame_tgl_q <= ~frame_tgl_q;
         dual_rd_q <= 1'b0;
         hires_rd_q <= 1'b0;
      end
      else if (data_byte_end && rd_mode_q)
      begin
         dual_rd_q <= dual_rd_q | ptr_is_dual;
         hires_rd_q <= hires_rd_q | ptr_is_hires;
      end
      else if (data_byte_end && wcnt_q < BURST_MAX_CNT)
      begin
         // Bytes past the burst limit are dropped silently
         wbuf_q[wcnt_q[2:0]] <= rx_byte;
         wcnt_q <= wcnt_q + 4'h1;
      end
   end

   // Read data comes from registers frozen for the whole frame
   always_comb
   begin
      unique case (ptr_q)
         ADDR_LOSS_HI_L: rd_data = loss_upper_limit_q[7:0];
         ADDR_LOSS_HI_H: rd_data = loss_upper_limit_q[15:8];
         ADDR_LOSS_LO_L: rd_data = loss_lower_limit_q[7:0];
         ADDR_LOSS_LO_H: rd_data = loss_lower_limit_q[15:8];
         ADDR_ROUTE: rd_data = irq_route_reg_q;
         ADDR_IND_HI_L: rd_data = inductance_upper_limit_q[7:0];
         ADDR_IND_HI_H: rd_data = inductance_upper_limit_q[15:8];
         ADDR_IND_LO_L: rd_data = inductance_lower_limit_q[7:0];
         ADDR_IND_LO_H: rd_data = inductance_lower_limit_q[15:8];
         ADDR_STATUS: rd_data = snap_status_q;
         ADDR_LOSS_RES_L: rd_data = snap_loss_q[7:0];
         ADDR_LOSS_RES_H: rd_data = snap_loss_q[15:8];
         ADDR_IND_RES_L: rd_data = snap_ind_q[7:0];
         ADDR_IND_RES_H: rd_data = snap_ind_q[15:8];
         ADDR_HIRES_0: rd_data = snap_hires_q[7:0];
         ADDR_HIRES_1: rd_data = snap_hires_q[15:8];
         ADDR_HIRES_2: rd_data = snap_hires_q[23:16];
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(negedge spi_clk or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         sd_q <= 8'h00;
         rd_phase_q <= 1'b0;
      end
      else if (bit_cnt_q == 3'h0 && cmd_done_q && rd_mode_q)
      begin
         sd_q <= rd_data;
         rd_phase_q <= 1'b1;
      end
      else
         sd_q <= {sd_q[6:0], 1'b0};
   end

   // Frame end and frame count cross as a level and a toggle
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         tg_s1_q <= 1'b0;
         tg_s2_q <= 1'b0;
         tg_done_q <= 1'b0;
      end
      else
      begin
         cs_s1_q <= chip_select_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         tg_s1_q <= frame_tgl_q;
         tg_s2_q <= tg_s1_q;
         if (cs_s2_q && !cs_s3_q)
            tg_done_q <= tg_s2_q;
      end
   end

   // Burst contents are stable here: the link clock is idle between frames
   wire commit = cs_s2_q & ~cs_s3_q & (tg_s2_q != tg_done_q);
   wire wr_commit = commit & wr_frame_q;
   wire hires_clear = commit & hires_rd_q;
   wire dual_clear = commit & dual_rd_q;

   always_comb
   begin
      logic [6:0] a;
      a = 7'h00;
      loss_upper_limit_d = loss_upper_limit_q;
      loss_lower_limit_d = loss_lower_limit_q;
      inductance_upper_limit_d = inductance_upper_limit_q;
      inductance_lower_limit_d = inductance_lower_limit_q;
      irq_route_reg_d = irq_route_reg_q;
      route_hit = 1'b0;
      for (int i = 0; i < BURST_MAX; i++)
      begin
         a = wstart_q + 7'(i);
         if (4'(i) < wcnt_q)
         begin
            unique case (a)
               ADDR_LOSS_HI_L: loss_upper_limit_d[7:0] = wbuf_q[i];
               ADDR_LOSS_HI_H: loss_upper_limit_d[15:8] = wbuf_q[i];
               ADDR_LOSS_LO_L: loss_lower_limit_d[7:0] = wbuf_q[i];
               ADDR_LOSS_LO_H: loss_lower_limit_d[15:8] = wbuf_q[i];
               ADDR_IND_HI_L: inductance_upper_limit_d[7:0] = wbuf_q[i];
               ADDR_IND_HI_H: inductance_upper_limit_d[15:8] = wbuf_q[i];
               ADDR_IND_LO_L: inductance_lower_limit_d[7:0] = wbuf_q[i];
               ADDR_IND_LO_H: inductance_lower_limit_d[15:8] = wbuf_q[i];
               ADDR_ROUTE:
               begin
                  irq_route_reg_d = wbuf_q[i] & ROUTE_FIELD_MASK;
                  route_hit = 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         loss_upper_limit_q <= LIMIT_RESET;
         loss_lower_limit_q <= LIMIT_RESET;
         inductance_upper_limit_q <= LIMIT_RESET;
         inductance_lower_limit_q <= LIMIT_RESET;
         irq_route_reg_q <= ROUTE_RESET;
      end
      else if (wr_commit)
      begin
         // Taken in any mode, used from the next dual result on
         loss_upper_limit_q <= loss_upper_limit_d;
         loss_lower_limit_q <= loss_lower_limit_d;
         inductance_upper_limit_q <= inductance_upper_limit_d;
         inductance_lower_limit_q <= inductance_lower_limit_d;
         irq_route_reg_q <= irq_route_reg_d;
      end
   end

   // Only dual results enter the comparators, unsigned
   wire loss_over = dual_done & (loss_result > loss_upper_limit_q);
   wire loss_under = dual_done & (loss_result < loss_lower_limit_q);
   wire ind_over = dual_done & (ind_result > inductance_upper_limit_q);
   wire ind_under = dual_done & (ind_result < inductance_lower_limit_q);
   wire [5:0] irq_source_select = irq_route_reg_q[5:0];
   wire irq_on_miso_enable = irq_route_reg_q[ROUTE_EN_BIT];
   wire latch_trip = (irq_source_select == SRC_LOSS_ABOVE_LATCH & loss_over) |
                     (irq_source_select == SRC_IND_ABOVE_LATCH & ind_over) |
                     (irq_source_select == SRC_HIRES_READY & hires_done);
   wire latch_clear = (wr_commit & route_hit) |
                      (hires_clear & irq_source_select == SRC_HIRES_READY);

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         loss_above_q <= 1'b0;
         loss_win_q <= 1'b0;
         ind_above_q <= 1'b0;
         ind_win_q <= 1'b0;
         latch_q <= 1'b0;
         dual_irq_q <= 1'b0;
         dual_pend_q <= 1'b0;
      end
      else
      begin
         if (dual_done)
         begin
            loss_above_q <= loss_over;
            ind_above_q <= ind_over;
         end
         if (loss_over || loss_under)
            loss_win_q <= loss_over;
         if (ind_over || ind_under)
            ind_win_q <= ind_over;
         // Set wins over a clear in the same cycle
         latch_q <= latch_trip | (latch_q & ~latch_clear);
         dual_irq_q <= dual_done | (dual_irq_q & ~dual_soon);
         dual_pend_q <= dual_done | (dual_pend_q & ~dual_clear);
      end
   end

   logic irq_level;
   always_comb
   begin
      unique case (irq_source_select)
         SRC_HIRES_READY: irq_level = latch_q;
         SRC_IND_WINDOW: irq_level = ind_win_q;
         SRC_IND_ABOVE_LATCH: irq_level = latch_q;
         SRC_DUAL_READY: irq_level = dual_irq_q;
         SRC_LOSS_WINDOW: irq_level = loss_win_q;
         SRC_LOSS_ABOVE_LATCH: irq_level = latch_q;
         default: irq_level = 1'b0;
      endcase
   end

   wire [7:0] status_now = {1'b0, ~dual_pend_q, ~loss_above_q, ~loss_win_q,
                            ~ind_above_q, ~ind_win_q, 2'b00};

   // Snapshot frozen while selected so a frame never sees a torn result
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         snap_status_q <= 8'h00;
         snap_loss_q <= 16'h0000;
         snap_ind_q <= 16'h0000;
         snap_hires_q <= 24'h000000;
         int_q <= 1'b1;
         int_oe_q <= 1'b0;
      end
      else
      begin
         if (cs_s2_q)
         begin
            snap_status_q <= status_now;
            snap_loss_q <= dual_done ? loss_result : snap_loss_q;
            snap_ind_q <= dual_done ? ind_result : snap_ind_q;
            snap_hires_q <= hires_done ? hires_result : snap_hires_q;
         end
         int_q <= ~irq_level;
         int_oe_q <= ~cs_s2_q & irq_on_miso_enable;
      end
   end

   // Pin mux between two flops; read data takes over once a read starts
   assign miso_out = rd_phase_q ? sd_q[7] : int_q;
   assign miso_oe = rd_phase_q | int_oe_q;
endmodule

// ---- core/crtc_pkg.sv ----
package crtc_pkg;
   // Register byte addresses (low byte first for 16/24-bit values)
   localparam logic [6:0] ADDR_LOSS_HI_L = 7'h06;
   localparam logic [6:0] ADDR_LOSS_HI_H = 7'h07;
   localparam logic [6:0] ADDR_LOSS_LO_L = 7'h08;
   localparam logic [6:0] ADDR_LOSS_LO_H = 7'h09;
   localparam logic [6:0] ADDR_ROUTE = 7'h0a;
   localparam logic [6:0] ADDR_IND_HI_L = 7'h16;
   localparam logic [6:0] ADDR_IND_HI_H = 7'h17;
   localparam logic [6:0] ADDR_IND_LO_L = 7'h18;
   localparam logic [6:0] ADDR_IND_LO_H = 7'h19;
   localparam logic [6:0] ADDR_STATUS = 7'h20;
   localparam logic [6:0] ADDR_LOSS_RES_L = 7'h21;
   localparam logic [6:0] ADDR_LOSS_RES_H = 7'h22;
   localparam logic [6:0] ADDR_IND_RES_L = 7'h23;
   localparam logic [6:0] ADDR_IND_RES_H = 7'h24;
   localparam logic [6:0] ADDR_HIRES_0 = 7'h38;
   localparam logic [6:0] ADDR_HIRES_1 = 7'h39;
   localparam logic [6:0] ADDR_HIRES_2 = 7'h3a;
   // Interrupt routing register fields
   localparam int ROUTE_EN_BIT = 7;
   localparam logic [7:0] ROUTE_FIELD_MASK = 8'hbf;
   // Interrupt source select codes
   localparam logic [5:0] SRC_NONE = 6'h00;
   localparam logic [5:0] SRC_LOSS_ABOVE_LATCH = 6'h01;
   localparam logic [5:0] SRC_LOSS_WINDOW = 6'h02;
   localparam logic [5:0] SRC_DUAL_READY = 6'h04;
   localparam logic [5:0] SRC_IND_ABOVE_LATCH = 6'h08;
   localparam logic [5:0] SRC_IND_WINDOW = 6'h10;
   localparam logic [5:0] SRC_HIRES_READY = 6'h20;
   // Status register bit positions
   localparam int STAT_DUAL_READY_N_BIT = 6;
   localparam int STAT_LOSS_ABOVE_BIT = 5;
   localparam int STAT_LOSS_WINDOW_BIT = 4;
   localparam int STAT_IND_ABOVE_BIT = 3;
   localparam int STAT_IND_WINDOW_BIT = 2;
   // Reset values
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   // Longest write burst kept per frame, in data bytes
   localparam int BURST_MAX = 8;
   localparam logic [3:0] BURST_MAX_CNT = 4'h8;
endpackage

// ---- dv/crtc_core_props.sv ----
`timescale 1ns/1ns
module crtc_core_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Serial link
   input wire logic spi_clk,
   input wire logic chip_select_n,
   input wire logic mosi,
   input wire logic miso_out,
   input wire logic miso_oe,
   // Converter results
   input wire logic dual_done,
   input wire logic dual_soon,
   input wire logic [15:0] loss_result,
   input wire logic [15:0] ind_result,
   input wire logic hires_done,
   input wire logic [23:0] hires_result
);
   logic act_q;
   logic [2:0] sel_q;
   logic [3:0] dd_q, ds_q, hd_q;
   logic calm;
   // Clocks seen in this frame: read data may own the pin then
   always_ff @(posedge spi_clk or posedge chip_select_n)
   begin
      if (chip_select_n)
         act_q <= 1'b0;
      else
         act_q <= 1'b1;
   end
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         sel_q <= 3'h0;
      else if (chip_select_n)
         sel_q <= 3'h0;
      else if (sel_q != 3'h7)
         sel_q <= sel_q + 3'h1;
   end
   always_ff @(posedge sys_clk)
   begin
      dd_q <= {dd_q[2:0], dual_done};
      ds_q <= {ds_q[2:0], dual_soon};
      hd_q <= {hd_q[2:0], hires_done};
   end
   // Settled selection with no serial traffic: pin shows the interrupt only
   assign calm = !act_q && sel_q > 3'h4;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_reset_idle: assert property ($fell(reset) |-> !miso_oe && miso_out)
      else $error("pin not idle after reset");
   a_oe_late: assert property ($fell(chip_select_n) |-> !miso_oe)
      else $error("pin driven before select");
   a_oe_rise_sel: assert property ($rose(miso_oe)
      |-> !chip_select_n && !$past(chip_select_n))
      else $error("pin driven without select");
   a_oe_drop: assert property (chip_select_n [*4] |-> !miso_oe)
      else $error("pin still driven after deselect");
   a_oe_hold: assert property (miso_oe && !chip_select_n ##1 !chip_select_n |-> miso_oe)
      else $error("pin released inside frame");
   a_fall_cause: assert property (calm && $past(calm) && miso_oe && $past(miso_oe)
      && $fell(miso_out) |-> (|dd_q[3:1]) || (|hd_q[3:1]))
      else $error("interrupt asserted without completion");
   a_rise_cause: assert property (calm && $past(calm) && miso_oe && $past(miso_oe)
      && $rose(miso_out) |-> (|ds_q[3:1]) || (|dd_q[3:1]))
      else $error("interrupt released without cause");
   a_out_steady: assert property (calm && $past(calm) && miso_oe
      && !(|{dd_q, ds_q, hd_q}) |-> $stable(miso_out))
      else $error("interrupt moved with no event");
   c_fall: cover property (calm && $fell(miso_out));
   c_rise: cover property (calm && $rose(miso_out));
   c_read: cover property (act_q && miso_oe);
endmodule
bind crtc_core crtc_core_props crtc_core_props_i (.sys_clk, .reset, .spi_clk, .chip_select_n,
   .mosi, .miso_out, .miso_oe, .dual_done, .dual_soon, .loss_result, .ind_result,
   .hires_done, .hires_result);

// ---- dv/crtc_host.sv ----
`timescale 1ns/1ns
module crtc_host (
   // Serial link
   output logic spi_clk,
   output logic chip_select_n,
   output logic mosi,
   input wire logic miso_out,
   input wire logic miso_oe
);
   initial
   begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      mosi = 1'b0;
   end
   // Frames are timed by the bench, never by the other measurement's ready
   task automatic sel(input logic v);
   begin
      chip_select_n = v;
      #300;
   end
   endtask
   // One short burst, low byte first; limits written at most once per interval
   task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
      output logic [31:0] rd);
      logic [39:0] sh;
   begin
      sh = {wd, cmd};
      rd = '0;
      sel(1'b0);
      for (int b = 0; b <= n; b++)
         for (int i = 7; i >= 0; i--)
         begin
            mosi = sh[8*b+i];
            #7 spi_clk = 1'b1;
            // A floating pin reads as z and never matches
            if (b > 0)
               rd[8*(b-1)+i] = miso_oe ? miso_out : 1'bz;
            #8 spi_clk = 1'b0;
         end
      mosi = ~mosi;
      sel(1'b1);
   end
   endtask
endmodule

// ---- dv/test_conversion_ready_and_threshold_compare.sv ----
`timescale 1ns/1ns
module test_conversion_ready_and_threshold_compare;
   import crtc_pkg::*;
   typedef struct packed {
      logic [7:0] route;
      logic [15:0] loss, ind;
      logic irq;
      logic [4:0] st;
   } crtc_row_s;
   logic sys_clk, reset, dual_done, dual_soon, hires_done;
   logic spi_clk, chip_select_n, mosi, miso_out, miso_oe;
   logic [15:0] loss_result, ind_result;
   logic [23:0] hires_result;
   logic [31:0] rd;
   logic [7:0] prev;
   int n_errors = 0;
   int checks = 0;
   // Status bits 6..2 expected; hysteresis state carries from row to row
   crtc_row_s rows [11] = '{
      '{8'h82, 16'h3001, 16'h1000, 1'b0, 5'h03}, '{8'h82, 16'h2500, 16'h1000, 1'b0, 5'h0b},
      '{8'h82, 16'h1fff, 16'h1000, 1'b1, 5'h0f}, '{8'h90, 16'h3000, 16'h5001, 1'b0, 5'h0c},
      '{8'h90, 16'h0000, 16'h4000, 1'b0, 5'h0e}, '{8'h81, 16'hffff, 16'h3fff, 1'b0, 5'h03},
      '{8'h81, 16'h0000, 16'h3fff, 1'b0, 5'h0f}, '{8'h88, 16'h1000, 16'h5000, 1'b1, 5'h0f},
      '{8'h88, 16'h1000, 16'h5001, 1'b0, 5'h0c}, '{8'h84, 16'h1000, 16'h3000, 1'b0, 5'h0f},
      '{8'h80, 16'h3001, 16'h3000, 1'b1, 5'h03}};
   crtc_core crtc_core_i (.sys_clk, .reset, .spi_clk, .chip_select_n, .mosi, .miso_out,
      .miso_oe, .dual_done, .dual_soon, .loss_result, .ind_result, .hires_done, .hires_result);
   crtc_host crtc_host_i (.spi_clk, .chip_select_n, .mosi, .miso_out, .miso_oe);
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, got);
   begin
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   task automatic report_and_stop;
   begin
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task automatic wr(input logic [6:0] a, input int n, input logic [31:0] d);
      crtc_host_i.frame({1'b0, a}, n, d, rd);
   endtask
   task automatic rdr(input logic [6:0] a, input int n);
      crtc_host_i.frame({1'b1, a}, n, 32'h0, rd);
   endtask
   // Results change to their inverse once the completion pulse is gone
   task automatic dual(input logic [15:0] l, i);
   begin
      @(posedge sys_clk) #2;
      loss_result = l;
      ind_result = i;
      dual_done = 1'b1;
      @(posedge sys_clk) #2;
      dual_done = 1'b0;
      loss_result = ~l;
      ind_result = ~i;
      repeat (4) @(posedge sys_clk);
      #2;
   end
   endtask
   task automatic look(input logic exp);
   begin
      crtc_host_i.sel(1'b0);
      chk("pin enable", 1, miso_oe);
      chk("interrupt level", exp, miso_out);
      crtc_host_i.sel(1'b1);
   end
   endtask
   initial
   begin
      reset = 1'b1;
      {dual_done, dual_soon, hires_done} = 3'h0;
      loss_result = 16'h0;
      ind_result = 16'h0;
      hires_result = 24'h0;
      repeat (16) @(posedge sys_clk);
      #2 reset = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      rdr(ADDR_LOSS_HI_L, 4);
      chk("limit reset", {2{LIMIT_RESET}}, rd);
      wr(ADDR_LOSS_HI_L, 4, 32'h2000_3000);
      wr(ADDR_IND_HI_L, 4, 32'h4000_5000);
      rdr(ADDR_IND_HI_L, 4);
      chk("inductance limits", 32'h4000_5000, rd);
      rdr(7'h7f, 1);
      chk("unmapped", 32'h0, rd);
      prev = 8'h00;
      foreach (rows[k])
      begin
         if (rows[k].route !== prev)
            wr(ADDR_ROUTE, 1, rows[k].route);
         prev = rows[k].route;
         dual(rows[k].loss, rows[k].ind);
         look(rows[k].irq);
         rdr(ADDR_STATUS, 1);
         chk("status", rows[k].st, rd[6:2]);
      end
      wr(ADDR_ROUTE, 1, 8'h81);
      dual(16'h3001, 16'h3000);
      look(1'b0);
      wr(ADDR_ROUTE, 1, 8'h80);
      wr(ADDR_ROUTE, 1, 8'h81);
      look(1'b1);
      rdr(ADDR_LOSS_RES_L, 4);
      chk("dual results", 32'h3000_3001, rd);
      rdr(ADDR_STATUS, 1);
      chk("status after result read", 5'h13, rd[6:2]);
      wr(ADDR_ROUTE, 1, 8'h84);
      crtc_host_i.sel(1'b0);
      // Release the ready left over from earlier results before looking for a new one
      @(posedge sys_clk) #2;
      dual_soon = 1'b1;
      @(posedge sys_clk) #2;
      dual_soon = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      chk("dual idle", 1, miso_out);
      dual(16'h1000, 16'h3000);
      chk("dual ready", 0, miso_out);
      @(posedge sys_clk) #2;
      dual_soon = 1'b1;
      @(posedge sys_clk) #2;
      dual_soon = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      chk("dual release", 1, miso_out);
      crtc_host_i.sel(1'b1);
      wr(ADDR_ROUTE, 1, 8'ha0);
      @(posedge sys_clk) #2;
      hires_result = 24'hfedcba;
      hires_done = 1'b1;
      @(posedge sys_clk) #2;
      hires_done = 1'b0;
      repeat (4) @(posedge sys_clk);
      #2;
      look(1'b0);
      rdr(ADDR_STATUS, 1);
      chk("status after hires", 5'h0f, rd[6:2]);
      rdr(ADDR_HIRES_0, 3);
      chk("hires result", 32'h00fedcba, rd);
      look(1'b1);
      // Reset in mid-run must bring limits and routing back
      @(posedge sys_clk) #2;
      reset = 1'b1;
      repeat (2) @(posedge sys_clk);
      #2 reset = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      rdr(ADDR_LOSS_HI_L, 4);
      chk("limits after reset", {2{LIMIT_RESET}}, rd);
      rdr(ADDR_ROUTE, 1);
      chk("route after reset", ROUTE_RESET, rd);
      report_and_stop;
   end
   initial
   begin
      #1000000;
      n_errors++;
      report_and_stop;
   end
endmodule
